// ### hdl/adc_pkg.sv
// Types shared by the register access block
package adc_pkg;

  typedef enum logic [1:0] {
    ST_CMD,
    ST_WRITE,
    ST_READ
  } port_state_e;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_STANDBY,
    PWR_SLEEP
  } pwr_mode_e;

  typedef struct packed {
    logic power_save_select;
    logic power_down_bit;
    logic system_reset_bit;
    logic reset_valid_flag;
    logic input_short_bit;
    logic guard_output_bit;
    logic reference_capacitor_select;
    logic [1:0] latch_bits;
    logic latch_source_select;
    logic unused_21;
    logic calib_source_select;
    logic rate_scaling_bit;
    logic [18:0] unused_low;
  } cfg_s;

  typedef struct packed {
    logic [1:0] channel_select_field;
    logic [2:0] gain_code;
    logic [3:0] word_rate;
    logic unipolar;
    logic [1:0] latch_bits;
    logic settle_delay;
    logic open_detect;
    logic [1:0] calib_set_pointer;
  } setup_s;

endpackage : adc_pkg

// ### hdl/adc_register_access_config.sv
// Serial register port and configuration control of the converter
// Function
// - Offset, gain, config and setup registers read and write.
// - Command 0x02 writes the gain register of physical channel one.
// - Read command makes the device shift out the 32-bit register word.
// - After a single read or write the port waits for a command byte.
// - Array commands reach all gain, offset or setup registers; 0x42 writes all gains.
// - Four setup registers always; four gain and offset registers here.
// - Array members are accessed in ascending order, then command mode returns.
// - Configuration is a 32-bit word with only the function bits stored.
// - Power-down bit set halts filtering and powers down analog circuitry.
// - Power-down with select at 0 gives standby, oscillator kept running.
// - Both bits set gives sleep; restart waits 20 ms unless clock is external.
// - Gain amplifier is powered down when the active gain code is unity.
// - Writing 1 to the system reset bit resets the config, offset, gain and setup registers.
// - System reset sets the reset valid flag; a configuration read clears it.
// - Reset loads zero config and setups, zero offsets, printed gain default.
// - Reset-starting write sets only the reset and reset valid bits; the next write clears reset, a third sets others.
// - Input short bit disconnects and ties all multiplexer inputs together.
// - Guard bit replaces the first latch pin with the common-mode voltage.
// - Latch pins follow the active setup, or the config bits when selected.
// - Calibration words come from the setup channel, or its pointer when selected.
// - Configuration fields sit at bits 31 down to 19 as laid out.
// - The reset valid flag is read only; the written bit is ignored, but a reset-starting write sets it.
// - Channel select sits in bits 31:30 and 15:14 of each setup pair.
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_register_access_config #(
  parameter logic [`OSC_CNT_W-1:0] OSC_START_CYC = `OSC_CNT_W'(`OSC_START_MS * (`CLK_HZ / 1000))
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic ext_clock_i,
  input wire logic [2:0] setup_sel_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [1:0] latch_output_pins_o,
  output logic guard_en_o,
  output logic input_short_o,
  output logic ref_cap_sel_o,
  output logic rate_scale_o,
  output adc_pkg::pwr_mode_e power_mode_o,
  output logic osc_ready_o,
  output logic amp_power_o,
  output logic [31:0] cal_offset_o,
  output logic [31:0] cal_gain_o
);
  import adc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic ext_clk_s;

  // Chip select idles high; a low reset value would select the port for two cycles
  bit_sync #(
    .W(4),
    .RST_VAL(4'h2)
  ) u_pin_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({ext_clock_i, sdi_i, cs_n_i, sclk_i}),
    .q_o(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign ext_clk_s = pins_s[3];

  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // Edges only count while chip select is low
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port state and command decode

  port_state_e st_q;
  logic [5:0] cnt_q;
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic [7:0] cmd_q;
  logic [1:0] idx_q;
  logic arm_q;
  logic sdo_q;
  logic sdo_oe_q;

  logic [31:0] rx_next;
  logic [7:0] cmd_sel;
  logic [2:0] sel_reg;
  logic sel_arr;
  logic sel_read;
  logic [1:0] sel_chan;
  logic cmd_valid;
  logic cmd_done;
  logic word_done;
  logic more_words;
  logic [1:0] tgt_idx;
  logic [1:0] rd_idx;

  assign rx_next = {rx_q[30:0], sdi_s};
  // A byte still being shifted is decoded straight from the shifter
  assign cmd_sel = (st_q == ST_CMD) ? rx_next[7:0] : cmd_q;
  assign sel_reg = cmd_sel[2:0];
  assign sel_arr = cmd_sel[`CMD_ARRAY_BIT];
  assign sel_read = cmd_sel[`CMD_READ_BIT];
  assign sel_chan = cmd_sel[`CMD_CHAN_HI:`CMD_CHAN_LO];

  // Configuration has no array form; conversion commands are not handled here
  assign cmd_valid = ~cmd_sel[`CMD_CONV_BIT]
                   & ((sel_reg == `REG_OFFSET) | (sel_reg == `REG_GAIN) | (sel_reg == `REG_SETUP)
                   | ((sel_reg == `REG_CONFIG) & ~sel_arr));

  assign cmd_done = (st_q == ST_CMD) & sclk_rise & (cnt_q == `CMD_LAST_BIT);
  assign word_done = (st_q != ST_CMD) & sclk_rise & (cnt_q == `WORD_LAST_BIT);
  assign more_words = sel_arr & (idx_q != `ARRAY_LAST);
  assign tgt_idx = sel_arr ? idx_q : sel_chan;
  assign rd_idx = (st_q == ST_CMD) ? (sel_arr ? 2'h0 : sel_chan) : 2'(idx_q + 2'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  cfg_s cfg_q;
  cfg_s cfg_d;
  logic wr_fire;
  logic sys_rst;
  logic slot_rst;
  logic cfg_we;
  logic cfg_rd;
  logic [31:0] off_w [`NUM_CAL];
  logic [31:0] gain_w [`NUM_CAL];
  logic [31:0] setup_w [`NUM_SETUP];

  assign wr_fire = (st_q == ST_WRITE) & word_done;
  assign cfg_we = wr_fire & (sel_reg == `REG_CONFIG);
  assign cfg_rd = cmd_done & cmd_valid & sel_read & (sel_reg == `REG_CONFIG);
  // Reset only starts from a write while the reset bit is still clear
  assign sys_rst = cfg_we & ~cfg_q.system_reset_bit & rx_next[`CFG_RS];
  assign slot_rst = srst_i | sys_rst;

  for (genvar i = 0; i < `NUM_CAL; i++) begin : g_cal
    calib_slot #(
      .RST_VAL(`OFFSET_RST)
    ) u_offset (
      .clk_i(clk_i),
      .srst_i(slot_rst),
      .we_i(wr_fire & (sel_reg == `REG_OFFSET) & (tgt_idx == 2'(i))),
      .d_i(rx_next),
      .q_o(off_w[i])
    );
    calib_slot #(
      .RST_VAL(`GAIN_RST)
    ) u_gain (
      .clk_i(clk_i),
      .srst_i(slot_rst),
      .we_i(wr_fire & (sel_reg == `REG_GAIN) & (tgt_idx == 2'(i))),
      .d_i(rx_next),
      .q_o(gain_w[i])
    );
  end

  for (genvar i = 0; i < `NUM_SETUP; i++) begin : g_setup
    calib_slot #(
      .RST_VAL(`SETUP_RST)
    ) u_setup (
      .clk_i(clk_i),
      .srst_i(slot_rst),
      .we_i(wr_fire & (sel_reg == `REG_SETUP) & (tgt_idx == 2'(i))),
      .d_i(rx_next),
      .q_o(setup_w[i])
    );
  end

  always_comb begin
    cfg_d = cfg_q;
    if (sys_rst) begin
      cfg_d = cfg_s'(`CFG_RST);
      cfg_d.system_reset_bit = 1'b1;
      cfg_d.reset_valid_flag = 1'b1;
    end else if (cfg_we) begin
      if (cfg_q.system_reset_bit) begin
        // The clearing write only ends the reset; other bits need another write
        cfg_d.system_reset_bit = 1'b0;
      end else begin
        cfg_d = cfg_s'(rx_next & `CFG_USED_MASK);
        cfg_d.reset_valid_flag = cfg_q.reset_valid_flag;
      end
    end else if (cfg_rd) begin
      cfg_d.reset_valid_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= cfg_s'(`CFG_RST);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  logic [31:0] rd_word;

  assign rd_word = (sel_reg == `REG_OFFSET) ? off_w[rd_idx] :
                   (sel_reg == `REG_GAIN) ? gain_w[rd_idx] :
                   (sel_reg == `REG_SETUP) ? setup_w[rd_idx] :
                   32'(cfg_q);

  ////////////////////////////////////////////////////////////////////////////
  // Serial port sequencer

  always_ff @(posedge clk_i) begin
    if (srst_i || cs_n_s) begin
      // Raising chip select abandons any partial byte or word
      st_q <= ST_CMD;
      cnt_q <= 6'h00;
      rx_q <= 32'h0000_0000;
      tx_q <= 32'h0000_0000;
      cmd_q <= 8'h00;
      idx_q <= 2'h0;
      arm_q <= 1'b0;
    end else if (sclk_rise) begin
      rx_q <= rx_next;
      cnt_q <= 6'(cnt_q + 6'h01);
      case (st_q)
        ST_CMD: begin
          if (cnt_q == `CMD_LAST_BIT) begin
            cnt_q <= 6'h00;
            cmd_q <= rx_next[7:0];
            idx_q <= 2'h0;
            arm_q <= 1'b0;
            tx_q <= rd_word;
            if (cmd_valid) begin
              st_q <= sel_read ? ST_READ : ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (word_done) begin
            cnt_q <= 6'h00;
            if (more_words) begin
              idx_q <= 2'(idx_q + 2'h1);
            end else begin
              st_q <= ST_CMD;
            end
          end
        end
        ST_READ: begin
          arm_q <= 1'b1;
          if (word_done) begin
            cnt_q <= 6'h00;
            if (more_words) begin
              idx_q <= 2'(idx_q + 2'h1);
              tx_q <= rd_word;
              arm_q <= 1'b0;
            end else begin
              st_q <= ST_CMD;
            end
          end
        end
        default: begin
          st_q <= ST_CMD;
        end
      endcase
    end else if (sclk_fall && st_q == ST_READ && arm_q) begin
      // Shift only after the host has sampled the current bit
      tx_q <= {tx_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q <= tx_q[31];
      sdo_oe_q <= ~cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power modes and oscillator start-up

  pwr_mode_e mode_d;
  pwr_mode_e mode_q;
  logic [`OSC_CNT_W-1:0] osc_cnt_q;

  assign mode_d = !cfg_q.power_down_bit ? PWR_NORMAL :
                  (cfg_q.power_save_select ? PWR_SLEEP : PWR_STANDBY);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= PWR_NORMAL;
      osc_cnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      if (mode_d == PWR_SLEEP && !ext_clk_s) begin
        // Crystal restarts from cold, so hold off until it has settled
        osc_cnt_q <= OSC_START_CYC;
      end else if (mode_d == PWR_SLEEP) begin
        osc_cnt_q <= '0;
      end else if (osc_cnt_q != '0) begin
        osc_cnt_q <= `OSC_CNT_W'(osc_cnt_q - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active setup, latch pins and calibration selection

  logic [31:0] act_pair;
  setup_s act_setup;
  logic [1:0] cal_idx;
  logic [1:0] latch_src;

  assign act_pair = setup_w[setup_sel_i[2:1]];
  assign act_setup = setup_sel_i[0] ? setup_s'(act_pair[15:0]) : setup_s'(act_pair[31:16]);
  assign cal_idx = cfg_q.calib_source_select ? act_setup.calib_set_pointer
                                             : act_setup.channel_select_field;
  assign latch_src = cfg_q.latch_source_select ? cfg_q.latch_bits : act_setup.latch_bits;

  logic osc_ready_q;
  logic amp_power_q;
  logic [1:0] latch_q;
  logic guard_q;
  logic short_q;
  logic ref_cap_q;
  logic rate_q;
  logic [31:0] cal_off_q;
  logic [31:0] cal_gain_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_ready_q <= 1'b1;
      amp_power_q <= 1'b0;
      latch_q <= 2'h0;
      guard_q <= 1'b0;
      short_q <= 1'b0;
      ref_cap_q <= 1'b0;
      rate_q <= 1'b0;
      cal_off_q <= `OFFSET_RST;
      cal_gain_q <= `GAIN_RST;
    end else begin
      osc_ready_q <= (mode_d != PWR_SLEEP) && (osc_cnt_q == '0);
      amp_power_q <= (mode_d == PWR_NORMAL) && (act_setup.gain_code != 3'h0);
      // With the guard on, the first pin carries the amplifier midpoint instead
      latch_q <= {latch_src[1], cfg_q.guard_output_bit ? 1'b0 : latch_src[0]};
      guard_q <= cfg_q.guard_output_bit;
      short_q <= cfg_q.input_short_bit;
      ref_cap_q <= cfg_q.reference_capacitor_select;
      rate_q <= cfg_q.rate_scaling_bit;
      cal_off_q <= off_w[cal_idx];
      cal_gain_q <= gain_w[cal_idx];
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = sdo_oe_q;
  assign latch_output_pins_o = latch_q;
  assign guard_en_o = guard_q;
  assign input_short_o = short_q;
  assign ref_cap_sel_o = ref_cap_q;
  assign rate_scale_o = rate_q;
  assign power_mode_o = mode_q;
  assign osc_ready_o = osc_ready_q;
  assign amp_power_o = amp_power_q;
  assign cal_offset_o = cal_off_q;
  assign cal_gain_o = cal_gain_q;

endmodule : adc_register_access_config

// ### hdl/adc_regs.svh
// Command codes, field positions, reset values and timing for the register access block
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// Command byte layout: [7] must be 0, [6] array, [5:4] channel, [3] read, [2:0] register
`define CMD_ARRAY_BIT 6
`define CMD_CHAN_HI 5
`define CMD_CHAN_LO 4
`define CMD_READ_BIT 3
`define CMD_CONV_BIT 7
`define REG_OFFSET 3'h1
`define REG_GAIN 3'h2
`define REG_CONFIG 3'h3
`define REG_SETUP 3'h5

`define CMD_LAST_BIT 6'h07
`define WORD_LAST_BIT 6'h1f
`define ARRAY_LAST 2'h3
`define NUM_CAL 4
`define NUM_SETUP 4

`define CFG_RST 32'h0000_0000
`define OFFSET_RST 32'h0000_0000
`define GAIN_RST 32'h0010_0000
`define SETUP_RST 32'h0000_0000

`define CFG_PSS 31
`define CFG_PDW 30
`define CFG_RS 29
`define CFG_RV 28
`define CFG_IS 27
`define CFG_GB 26
`define CFG_VRS 25
`define CFG_LATCH_HI 24
`define CFG_LATCH_LO 23
`define CFG_OLS 22
`define CFG_OGS 20
`define CFG_FRS 19
`define CFG_USED_MASK 32'hffd8_0000

`define OSC_START_MS 20
`define CLK_HZ 40000000
`define OSC_CNT_W 20

`endif

// ### hdl/bit_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Reset to each pin's idle level so no false edge or select follows reset
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : bit_sync

// ### hdl/calib_slot.sv
// One 32-bit storage word with its own reset value and write strobe
`timescale 1ns/1ps
module calib_slot #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic we_i,
  input wire logic [31:0] d_i,
  output logic [31:0] q_o
);
  logic [31:0] word_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      word_q <= RST_VAL;
    end else if (we_i) begin
      word_q <= d_i;
    end
  end

  assign q_o = word_q;
endmodule : calib_slot

// ### tb/adc_register_access_config_props.sv
// Concurrent checks on the ports of the register access block
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_register_access_config_props #(
  parameter logic [`OSC_CNT_W-1:0] OSC_START_CYC = `OSC_CNT_W'(800000)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic ext_clock_i,
  input wire logic [2:0] setup_sel_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic [1:0] latch_output_pins_o,
  input wire logic guard_en_o,
  input wire logic input_short_o,
  input wire logic ref_cap_sel_o,
  input wire logic rate_scale_o,
  input adc_pkg::pwr_mode_e power_mode_o,
  input wire logic osc_ready_o,
  input wire logic amp_power_o,
  input wire logic [31:0] cal_offset_o,
  input wire logic [31:0] cal_gain_o
);
  import adc_pkg::*;
  int idle_cnt;
  int wait_cnt;
  // Counters replace long repetitions, which the tools would unroll
  always_ff @(posedge clk_i) begin
    idle_cnt <= (srst_i || !cs_n_i) ? 0 : idle_cnt + 1;
    wait_cnt <= (srst_i || osc_ready_o || power_mode_o == PWR_SLEEP) ? 0 : wait_cnt + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////
  property p_oe_on;
    !cs_n_i [*5] |-> sdo_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial output not driven while selected");
  property p_oe_off;
    cs_n_i [*5] |-> !sdo_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial output driven while deselected");
  property p_guard_a0;
    guard_en_o |-> !latch_output_pins_o[0];
  endproperty
  a_guard_a0: assert property (p_guard_a0) else $error("first latch pin active under guard");
  property p_sleep_osc;
    power_mode_o == PWR_SLEEP ##1 power_mode_o == PWR_SLEEP |-> !osc_ready_o;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator ready in sleep");
  property p_osc_wait;
    wait_cnt <= int'(OSC_START_CYC) + 4;
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("oscillator start took too long");
  property p_standby_osc;
    power_mode_o == PWR_STANDBY && $past(power_mode_o) == PWR_STANDBY && $past(osc_ready_o) |-> osc_ready_o;
  endproperty
  a_standby_osc: assert property (p_standby_osc) else $error("oscillator lost in standby");
  property p_amp_off;
    power_mode_o != PWR_NORMAL ##1 power_mode_o != PWR_NORMAL |-> !amp_power_o;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("amplifier powered in power save");
  property p_rst_vals;
    disable iff (1'b0)
    srst_i |=> power_mode_o == PWR_NORMAL && osc_ready_o && !amp_power_o && !guard_en_o && !input_short_o
      && !sdo_oe_o && latch_output_pins_o == 2'h0 && cal_offset_o == 32'h0 && cal_gain_o == 32'h0010_0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("wrong value under reset");
  property p_cfg_hold;
    idle_cnt > 8 && !$past(srst_i) |-> $stable(input_short_o) && $stable(guard_en_o)
      && $stable(ref_cap_sel_o) && $stable(rate_scale_o) && $stable(power_mode_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config output moved without access");
endmodule : adc_register_access_config_props

bind adc_register_access_config adc_register_access_config_props #(.OSC_START_CYC(OSC_START_CYC)) u_props (
  .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i), .ext_clock_i(ext_clock_i),
  .setup_sel_i(setup_sel_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .latch_output_pins_o(latch_output_pins_o),
  .guard_en_o(guard_en_o), .input_short_o(input_short_o), .ref_cap_sel_o(ref_cap_sel_o),
  .rate_scale_o(rate_scale_o), .power_mode_o(power_mode_o), .osc_ready_o(osc_ready_o),
  .amp_power_o(amp_power_o), .cal_offset_o(cal_offset_o), .cal_gain_o(cal_gain_o));

// ### tb/host_model.sv
// Host side of the serial port: frames, command bytes and data words
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // Half period of the serial clock in system clocks; raised for a slow host
  int half = 4;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk
  task automatic select(input logic on);
    wait_clk(half);
    cs_n_o <= ~on;
    if (!on) begin
      // A deselected data line shows the inverse of its last bit
      sdi_o <= ~sdi_o;
    end
    wait_clk(half);
  endtask : select
  // Read data is taken late in the high phase, where the device bit stands
  task automatic shift(input int n, input logic [31:0] w, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= w[i];
      wait_clk(half);
      sclk_o <= 1'b1;
      wait_clk(half);
      r[i] = sdo_oe_i ? sdo_i : 1'bx;
      sclk_o <= 1'b0;
    end
  endtask : shift
endmodule : host_model

// ### tb/tb.sv
// Self-checking bench for the register access block
`timescale 1ns/1ps
`include "adc_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  import adc_pkg::*;
  localparam logic [`OSC_CNT_W-1:0] OSC_SIM = `OSC_CNT_W'(40);
  localparam int LIMIT = 80000;
  logic clk_i, srst_i, sclk_i, cs_n_i, sdi_i, ext_clock_i, sdo_o, sdo_oe_o;
  logic guard_en_o, input_short_o, ref_cap_sel_o, rate_scale_o, osc_ready_o, amp_power_o;
  logic [2:0] setup_sel_i;
  logic [1:0] latch_output_pins_o;
  logic [31:0] cal_offset_o, cal_gain_o, m_cfg;
  pwr_mode_e power_mode_o;
  logic [31:0] wbuf [4], rbuf [4], m_off [4], m_gain [4], m_set [4];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  adc_register_access_config #(.OSC_START_CYC(OSC_SIM)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i), .ext_clock_i(ext_clock_i),
    .setup_sel_i(setup_sel_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .latch_output_pins_o(latch_output_pins_o),
    .guard_en_o(guard_en_o), .input_short_o(input_short_o), .ref_cap_sel_o(ref_cap_sel_o),
    .rate_scale_o(rate_scale_o), .power_mode_o(power_mode_o), .osc_ready_o(osc_ready_o),
    .amp_power_o(amp_power_o), .cal_offset_o(cal_offset_o), .cal_gain_o(cal_gain_o));
  host_model u_host (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
    .sdi_o(sdi_i));
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      complete_run();
    end
  end
  task automatic mdl_reset();
    m_cfg = 32'h0;
    for (int k = 0; k < 4; k++) begin
      m_off[k] = 32'h0;
      m_gain[k] = 32'h0010_0000;
      m_set[k] = 32'h0;
    end
  endtask : mdl_reset
  task automatic cfg_write(input logic [31:0] w);
    if (m_cfg[29]) begin
      m_cfg[29] = 1'b0;
    end else if (w[29]) begin
      mdl_reset();
      m_cfg = 32'h3000_0000;
    end else begin
      m_cfg = (w & `CFG_USED_MASK & ~32'h1000_0000) | (m_cfg & 32'h1000_0000);
    end
  endtask : cfg_write
  // One framed access; the model is updated after the frame so reads see the old state
  task automatic xfer(input logic [7:0] c, input int n);
    logic [31:0] r;
    int k;
    u_host.select(1'b1);
    u_host.shift(8, {24'h0, c}, r);
    for (int i = 0; i < n; i++) begin
      u_host.shift(32, wbuf[i], rbuf[i]);
    end
    u_host.select(1'b0);
    repeat (12) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      k = (n > 1) ? i : int'(c[5:4]);
      case ({c[3], c[2:0]})
        4'h1: m_off[k] = wbuf[i];
        4'h2: m_gain[k] = wbuf[i];
        4'h5: m_set[k] = wbuf[i];
        4'h9: `CHK("offset", m_off[k], rbuf[i])
        4'ha: `CHK("gain", m_gain[k], rbuf[i])
        4'hd: `CHK("setup", m_set[k], rbuf[i])
        4'hb: begin
          `CHK("config", m_cfg, rbuf[i])
          m_cfg[28] = 1'b0;
        end
        4'h3: cfg_write(wbuf[i]);
        default: ;
      endcase
    end
  endtask : xfer
  task automatic chk_out();
    logic [15:0] s;
    logic [1:0] k;
    logic [1:0] lat;
    for (int sel = 0; sel < 8; sel++) begin
      setup_sel_i <= 3'(sel);
      repeat (3) @(posedge clk_i);
      s = sel[0] ? m_set[sel / 2][15:0] : m_set[sel / 2][31:16];
      k = m_cfg[20] ? s[1:0] : s[15:14];
      lat = m_cfg[22] ? m_cfg[24:23] : s[5:4];
      lat[0] = lat[0] & ~m_cfg[26];
      `CHK("offset_sel", m_off[k], cal_offset_o)
      `CHK("gain_sel", m_gain[k], cal_gain_o)
      `CHK("latch", lat, latch_output_pins_o)
      `CHK("amp", !m_cfg[30] && s[13:11] != 3'h0, amp_power_o)
    end
    `CHK("short", m_cfg[27], input_short_o)
    `CHK("guard", m_cfg[26], guard_en_o)
    `CHK("refcap", m_cfg[25], ref_cap_sel_o)
    `CHK("rate", m_cfg[19], rate_scale_o)
    `CHK("mode", m_cfg[30] ? (m_cfg[31] ? PWR_SLEEP : PWR_STANDBY) : PWR_NORMAL, power_mode_o)
  endtask : chk_out
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [2:0] regs [3];
    logic [7:0] bad [3];
    clk_i = 1'b0;
    srst_i = 1'b1;
    ext_clock_i = 1'b0;
    setup_sel_i = 3'h0;
    regs = '{3'h1, 3'h2, 3'h5};
    bad = '{8'h83, 8'h04, 8'h43};
    wbuf = '{default: 32'h0};
    r = $urandom(90869);
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    mdl_reset();
    repeat (4) @(posedge clk_i);
    chk_out();
    // Refused bytes must leave the port ready for a command in the same frame
    foreach (bad[j]) begin
      u_host.select(1'b1);
      u_host.shift(8, {24'h0, bad[j]}, r);
      u_host.shift(8, 32'h0b, r);
      u_host.shift(32, 32'h0, r);
      u_host.select(1'b0);
      `CHK("after_refused", m_cfg, r)
    end
    foreach (regs[j]) begin
      xfer({4'h4, 1'b1, regs[j]}, 4);
      for (int i = 0; i < 4; i++) begin
        wbuf[i] = $urandom;
      end
      xfer({4'h4, 1'b0, regs[j]}, 4);
      xfer({4'h4, 1'b1, regs[j]}, 4);
      for (int i = 0; i < 4; i++) begin
        wbuf[0] = $urandom;
        xfer({2'b00, 2'(i), 1'b0, regs[j]}, 1);
        xfer({2'b00, 2'(i), 1'b1, regs[j]}, 1);
      end
    end
    wbuf[0] = 32'h8000_0000;
    xfer(8'h02, 1);
    xfer(8'h4a, 4);
    // A frame cut short must not store a partial word
    u_host.select(1'b1);
    u_host.shift(8, 32'h02, r);
    u_host.shift(16, $urandom, r);
    u_host.select(1'b0);
    xfer(8'h4a, 4);
    for (int i = 0; i < 6; i++) begin
      u_host.half = 4 + i % 3;
      ext_clock_i <= 1'($urandom);
      wbuf[0] = $urandom & ~32'h2000_0000;
      xfer(8'h03, 1);
      chk_out();
      xfer(8'h0b, 1);
    end
    u_host.half = 4;
    wbuf[0] = 32'hffff_ffff;
    xfer(8'h03, 1);
    xfer(8'h0b, 1);
    xfer(8'h0b, 1);
    xfer(8'h4a, 4);
    xfer(8'h49, 4);
    xfer(8'h4d, 4);
    wbuf[0] = 32'h0800_0000;
    xfer(8'h03, 1);
    xfer(8'h03, 1);
    chk_out();
    xfer(8'h0b, 1);
    for (int i = 0; i < 2; i++) begin
      ext_clock_i <= 1'(i);
      wbuf[0] = 32'hc000_0000;
      xfer(8'h03, 1);
      chk_out();
      `CHK("osc_sleep", 1'b0, osc_ready_o)
      wbuf[0] = 32'h0;
      xfer(8'h03, 1);
      `CHK("osc_wake", 1'(i), osc_ready_o)
      repeat (OSC_SIM + 10) @(posedge clk_i);
      `CHK("osc_up", 1'b1, osc_ready_o)
    end
    complete_run();
  end
endmodule : tb
